// *** rtl/sequencer_pkg.sv ***
// Shared constants and types of the color and proximity measurement sequencer
package sequencer_pkg;
	localparam int CLK_PERIOD_NS   = 20;
	localparam int STEP_TIME_NS    = 2400000;
	localparam int STEP_CYCLES     = STEP_TIME_NS / CLK_PERIOD_NS;
	localparam int PULSE_PERIOD_NS = 14000;
	localparam int PULSE_CYCLES    = PULSE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int LED_ON_NS       = 6300;
	localparam int LED_ON_CYCLES   = LED_ON_NS / CLK_PERIOD_NS;
	localparam int LONG_WAIT_MULT  = 12;
	localparam int UNIT_W          = 17;
	localparam int COUNT_W         = 12;

	// Register offsets
	localparam logic [4:0] REG_FUNC_ENABLE    = 5'h00;
	localparam logic [4:0] REG_COLOR_TIME     = 5'h01;
	localparam logic [4:0] REG_PROX_TIME      = 5'h02;
	localparam logic [4:0] REG_WAIT_TIME      = 5'h03;
	localparam logic [4:0] REG_THRESH_BASE    = 5'h04;
	localparam logic [4:0] REG_THRESH_LAST    = 5'h0B;
	localparam logic [4:0] REG_PERSIST_FILTER = 5'h0C;
	localparam logic [4:0] REG_CONFIG         = 5'h0D;
	localparam logic [4:0] REG_PULSE_COUNT    = 5'h0E;
	localparam logic [4:0] REG_GAIN_CONTROL   = 5'h0F;
	localparam logic [4:0] REG_DEVICE_ID      = 5'h12;
	localparam logic [4:0] REG_DEVICE_STATUS  = 5'h13;
	localparam logic [4:0] REG_DATA_BASE      = 5'h14;
	localparam logic [4:0] REG_DATA_LAST      = 5'h1D;

	// Reset values
	localparam logic [7:0] TIME_RESET = 8'hFF;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// Enable register bits
	localparam int BIT_POWER_ON     = 0;
	localparam int BIT_COLOR_EN     = 1;
	localparam int BIT_PROX_EN      = 2;
	localparam int BIT_WAIT_EN      = 3;
	localparam int BIT_COLOR_IRQ_EN = 4;
	localparam int BIT_PROX_IRQ_EN  = 5;
	localparam logic [7:0] ENABLE_WRITE_MASK = 8'h3F;

	// Other fields
	localparam int BIT_LONG_WAIT   = 1;
	localparam int BIT_COLOR_VALID = 0;
	localparam int BIT_PROX_VALID  = 1;
	localparam int BIT_COLOR_INT   = 4;
	localparam int BIT_PROX_INT    = 5;
	localparam int DRIVE_LSB       = 6;
	localparam int DIODE_LSB       = 4;
	localparam int GAIN_LSB        = 0;
	localparam int COLOR_PERS_LSB  = 0;
	localparam int PROX_PERS_LSB   = 4;
	localparam logic [1:0] DIODE_CLEAR = 2'h1;
	localparam logic [1:0] DIODE_RED   = 2'h2;
	localparam logic [1:0] DIODE_BOTH  = 2'h3;

	// Command byte
	localparam int BIT_CMD_SELECT = 7;
	localparam int CMD_TYPE_LSB   = 5;
	localparam logic [1:0] TYPE_AUTO    = 2'h1;
	localparam logic [1:0] TYPE_SPECIAL = 2'h3;
	localparam logic [4:0] SF_PROX_CLR  = 5'h05;
	localparam logic [4:0] SF_COLOR_CLR = 5'h06;
	localparam logic [4:0] SF_BOTH_CLR  = 5'h07;

	typedef enum logic [6:0] {
		S_SLEEP = 7'h01,
		S_PWRUP = 7'h02,
		S_START = 7'h04,
		S_PACC  = 7'h08,
		S_PCONV = 7'h10,
		S_WAIT  = 7'h20,
		S_COLOR = 7'h40
	} seq_state_t;
endpackage

// *** rtl/step_timer_if.sv ***
// Link between the sequencer and its step timer
`timescale 1ns/1ns
interface step_timer_if;
	import sequencer_pkg::*;
	logic               load;
	logic [UNIT_W-1:0]  unit_cycles;
	logic [COUNT_W-1:0] units;
	logic [UNIT_W-1:0]  cyc;
	logic               done;
	modport owner (output load, unit_cycles, units, input cyc, done);
	modport timer (input load, unit_cycles, units, output cyc, done);
endinterface

// *** rtl/step_timer.sv ***
// Step timer: counts whole units of a programmable cycle length
`timescale 1ns/1ns
module step_timer
	import sequencer_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   rst_n,
	step_timer_if.timer tmr
);
	typedef struct packed {
		logic               busy;
		logic [UNIT_W-1:0]  cyc;
		logic [COUNT_W-1:0] left;
	} timer_state_t;

	timer_state_t st;
	timer_state_t next_st;
	logic         unit_end;

	assign unit_end = st.busy && (st.cyc == tmr.unit_cycles - 1'b1);
	assign tmr.done = unit_end && (st.left == COUNT_W'(1));
	assign tmr.cyc  = st.cyc;

	always_comb begin
		next_st = st;
		if (tmr.load) begin
			next_st.busy = 1'b1;
			next_st.cyc  = '0;
			next_st.left = tmr.units;
		end else if (unit_end) begin
			next_st.cyc  = '0;
			next_st.left = st.left - 1'b1;
			if (st.left == COUNT_W'(1)) begin
				next_st.busy = 1'b0;
			end
		end else if (st.busy) begin
			next_st.cyc = st.cyc + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	AST_DONE_ENDS_RUN: assert property (@(posedge clk) disable iff (!rst_n)
		tmr.done && !tmr.load |=> !st.busy && tmr.cyc == '0) // R27
		else $error("timer kept running after its last unit");
endmodule

// *** rtl/color_proximity_measure_sequencer.sv ***
// Measurement sequencer, register file and interrupt logic of the sensor
`timescale 1ns/1ns
// Contract
// R1 - After reset sit in sleep, no conversions until power-on bit set.
// R2 - Power-on bit is bit 0 of enable register.
// R3 - After power-on written, wait 2.4 ms before the start state.
// R4 - From start run proximity, wait, color in order if enabled, repeat.
// R5 - Clearing power-on finishes conversions in progress, then sleeps.
// R6 - Proximity: accumulate, then conversion, advance as soon as it completes.
// R7 - Wait state lasts programmed wait time; long-wait bit makes it 12x.
// R8 - Wait counter end moves directly to color integration.
// R9 - Time registers count 256 minus value steps of 2.4 ms.
// R10 - Four color channels integrate together; results double-buffered.
// R11 - After color transfer advance to next state without host action.
// R12 - Diode select routes red, clear or both to proximity converter.
// R13 - Proximity result latched into data register at cycle end.
// R14 - Emit programmed 1 to 255 LED pulses of 14 us period.
// R15 - Drive strength setting selects LED sink current.
// R16 - Host programs proximity time at least one step.
// R17 - Interrupt evaluation always runs; enables only gate the output.
// R18 - Color event when clear data below low or above high threshold.
// R19 - Proximity event when data below low or above high threshold.
// R20 - Host keeps each low threshold below its high threshold.
// R21 - Persistence filters need consecutive out-of-range results before interrupt.
// R22 - Raised interrupt stays until special-function clear command.
// R23 - Host keeps color enabled with at least one step.
// R24 - Special commands 00101, 00110, 00111 clear proximity, color, both.
// R25 - Interrupt pin active low open drain while enabled interrupt pending.
// R26 - Enable bits: 5 prox irq, 4 color irq, 3 wait, 2 prox, 1 color.
// R27 - Timers count only while the power-on bit is set; code keeps a loaded timer counting after power-on clears, even in sleep.
module color_proximity_measure_sequencer
	import sequencer_pkg::*;
#(
	parameter int         STEP_CYC  = STEP_CYCLES,
	parameter logic [7:0] DEVICE_ID = 8'h5A // arbitrary value
)(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  cmd_byte,
	input  wire logic        wr_valid,
	input  wire logic [7:0]  wr_data,
	input  wire logic        rd_req,
	output logic      [7:0]  rd_data,
	output logic             rd_valid,
	input  wire logic [15:0] color_adc_clear,
	input  wire logic [15:0] color_adc_red,
	input  wire logic [15:0] color_adc_green,
	input  wire logic [15:0] color_adc_blue,
	input  wire logic [15:0] prox_adc_red,
	input  wire logic [15:0] prox_adc_clear,
	output logic             color_integrating,
	output logic             prox_integrating,
	output logic      [1:0]  color_gain_setting,
	output logic      [1:0]  prox_diode_select,
	output logic      [1:0]  led_drive_strength,
	input  wire logic        led_pin_i,
	output logic             led_pin_o,
	output logic             led_pin_oe,
	input  wire logic        irq_pin_i,
	output logic             irq_pin_o,
	output logic             irq_pin_oe
);
	typedef struct packed {
		seq_state_t       state;
		logic [7:0]       func_enable;
		logic [7:0]       color_integ_time;
		logic [7:0]       prox_integ_time;
		logic [7:0]       wait_time_count;
		logic [7:0][7:0]  thresholds;
		logic [7:0]       persist_filter;
		logic [7:0]       config_bits;
		logic [7:0]       led_pulse_count;
		logic [7:0]       gain_control;
		logic [3:0][15:0] color_result;
		logic [15:0]      prox_result;
		logic [7:0]       shadow;
		logic [4:0]       addr;
		logic             auto_inc;
		logic [3:0]       color_hits;
		logic [3:0]       prox_hits;
		logic             color_int;
		logic             prox_int;
		logic             color_valid;
		logic             prox_valid;
		logic [7:0]       rd_data;
		logic             rd_valid;
	} seq_regs_t;

	seq_regs_t    st;
	seq_regs_t    next_st;
	step_timer_if tmr ();

	logic        power_on_bit;
	logic        color_enable_bit;
	logic        prox_enable_bit;
	logic        wen;
	logic        long_wait;
	seq_state_t  after_wait;
	seq_state_t  after_prox;
	seq_state_t  after_start;
	seq_state_t  go;
	logic        go_valid;
	logic [15:0] prox_sel;
	logic        color_out;
	logic        prox_out;
	logic [4:0]  color_pers;
	logic [4:0]  prox_pers;
	logic        cmd_special;
	logic        prox_clr_cmd;
	logic        color_clr_cmd;
	logic [4:0]  data_idx;
	logic [15:0] data_word;
	logic        in_data;
	logic [7:0]  status_byte;
	logic [7:0]  read_mux;

	function automatic logic [COUNT_W-1:0] steps(input logic [7:0] t);
		return COUNT_W'(9'h100 - {1'b0, t});
	endfunction

	function automatic logic [4:0] persist(input logic [3:0] hits,
		input logic [3:0] field, input logic out);
		logic [3:0] need;
		logic [3:0] more;
		need = (field == 4'h0) ? 4'h1 : field;
		more = (hits == 4'hF) ? hits : hits + 4'h1;
		return out ? {(more >= need), more} : 5'h00;
	endfunction

	step_timer u_timer (
		.clk   (clk),
		.rst_n (rst_n),
		.tmr   (tmr)
	);

	// R2 power-on bit
	assign power_on_bit       = st.func_enable[BIT_POWER_ON];
	// R26 enable bit layout
	assign color_enable_bit       = st.func_enable[BIT_COLOR_EN];
	assign prox_enable_bit       = st.func_enable[BIT_PROX_EN];
	assign wen       = st.func_enable[BIT_WAIT_EN];
	assign long_wait = st.config_bits[BIT_LONG_WAIT];

	// R4 pass order
	assign after_wait  = color_enable_bit ? S_COLOR : S_START;
	assign after_prox  = wen ? S_WAIT : after_wait;
	assign after_start = !prox_enable_bit ? after_prox :
		(st.led_pulse_count != 8'h00) ? S_PACC : S_PCONV;

	// R12 diode routing
	always_comb begin
		case (st.gain_control[DIODE_LSB +: 2])
			DIODE_CLEAR: prox_sel = prox_adc_clear;
			DIODE_RED:   prox_sel = prox_adc_red;
			DIODE_BOTH: begin
				if ({1'b0, prox_adc_red} + {1'b0, prox_adc_clear} > 17'h0FFFF)
					prox_sel = 16'hFFFF;
				else
					prox_sel = prox_adc_red + prox_adc_clear;
			end
			default:     prox_sel = 16'h0000;
		endcase
	end

	// R18 color range check
	assign color_out = (color_adc_clear < {st.thresholds[1], st.thresholds[0]})
		|| (color_adc_clear > {st.thresholds[3], st.thresholds[2]});
	// R19 proximity range check
	assign prox_out = (prox_sel < {st.thresholds[5], st.thresholds[4]})
		|| (prox_sel > {st.thresholds[7], st.thresholds[6]});
	// R21 persistence filters
	assign color_pers = persist(st.color_hits,
		st.persist_filter[COLOR_PERS_LSB +: 4], color_out);
	assign prox_pers  = persist(st.prox_hits,
		st.persist_filter[PROX_PERS_LSB +: 4], prox_out);

	// R24 special-function clears
	assign cmd_special   = cmd_valid && cmd_byte[BIT_CMD_SELECT]
		&& cmd_byte[CMD_TYPE_LSB +: 2] == TYPE_SPECIAL;
	assign prox_clr_cmd  = cmd_special && (cmd_byte[4:0] == SF_PROX_CLR
		|| cmd_byte[4:0] == SF_BOTH_CLR);
	assign color_clr_cmd = cmd_special && (cmd_byte[4:0] == SF_COLOR_CLR
		|| cmd_byte[4:0] == SF_BOTH_CLR);

	// R17 status always visible
	always_comb begin
		status_byte                  = 8'h00;
		status_byte[BIT_COLOR_VALID] = st.color_valid;
		status_byte[BIT_PROX_VALID]  = st.prox_valid;
		status_byte[BIT_COLOR_INT]   = st.color_int;
		status_byte[BIT_PROX_INT]    = st.prox_int;
	end

	assign data_idx  = st.addr - REG_DATA_BASE;
	assign in_data   = st.addr >= REG_DATA_BASE && st.addr <= REG_DATA_LAST;
	assign data_word = (data_idx[4:1] == 4'h4) ? st.prox_result :
		st.color_result[data_idx[2:1]];

	always_comb begin
		case (st.addr)
			REG_FUNC_ENABLE:    read_mux = st.func_enable;
			REG_COLOR_TIME:     read_mux = st.color_integ_time;
			REG_PROX_TIME:      read_mux = st.prox_integ_time;
			REG_WAIT_TIME:      read_mux = st.wait_time_count;
			REG_PERSIST_FILTER: read_mux = st.persist_filter;
			REG_CONFIG:         read_mux = st.config_bits;
			REG_PULSE_COUNT:    read_mux = st.led_pulse_count;
			REG_GAIN_CONTROL:   read_mux = st.gain_control;
			REG_DEVICE_ID:      read_mux = DEVICE_ID;
			REG_DEVICE_STATUS:  read_mux = status_byte;
			default: begin
				if (st.addr >= REG_THRESH_BASE && st.addr <= REG_THRESH_LAST)
					read_mux = st.thresholds[3'(st.addr - REG_THRESH_BASE)];
				else if (in_data)
					read_mux = data_idx[0] ? st.shadow : data_word[7:0];
				else
					read_mux = 8'h00;
			end
		endcase
	end

	always_comb begin
		next_st          = st;
		next_st.rd_valid = 1'b0;
		go               = st.state;
		go_valid         = 1'b0;
		tmr.load         = 1'b0;
		// Accumulate counts pulse periods for its whole stay, not one cycle
		tmr.unit_cycles  = (st.state == S_PACC) ? UNIT_W'(PULSE_CYCLES)
			: UNIT_W'(STEP_CYC);
		tmr.units        = COUNT_W'(1);

		// Register port: command, then write, then read
		if (cmd_valid && cmd_byte[BIT_CMD_SELECT]) begin
			if (cmd_special) begin
				// R22 cleared only by command
				if (prox_clr_cmd)
					next_st.prox_int = 1'b0;
				if (color_clr_cmd)
					next_st.color_int = 1'b0;
			end else begin
				next_st.addr     = cmd_byte[4:0];
				next_st.auto_inc = cmd_byte[CMD_TYPE_LSB +: 2] == TYPE_AUTO;
			end
		end else if (wr_valid) begin
			case (st.addr)
				REG_FUNC_ENABLE:
					next_st.func_enable = wr_data & ENABLE_WRITE_MASK;
				REG_COLOR_TIME:     next_st.color_integ_time = wr_data;
				REG_PROX_TIME:      next_st.prox_integ_time = wr_data;
				REG_WAIT_TIME:      next_st.wait_time_count = wr_data;
				REG_PERSIST_FILTER: next_st.persist_filter = wr_data;
				REG_CONFIG:         next_st.config_bits = wr_data;
				REG_PULSE_COUNT:    next_st.led_pulse_count = wr_data;
				REG_GAIN_CONTROL:   next_st.gain_control = wr_data;
				default: begin
					if (st.addr >= REG_THRESH_BASE && st.addr <= REG_THRESH_LAST)
						next_st.thresholds[3'(st.addr - REG_THRESH_BASE)] = wr_data;
				end
			endcase
			if (st.auto_inc)
				next_st.addr = st.addr + 5'h01;
		end else if (rd_req) begin
			next_st.rd_data  = read_mux;
			next_st.rd_valid = 1'b1;
			// R10 high byte frozen at low-byte read
			if (in_data && !data_idx[0])
				next_st.shadow = data_word[15:8];
			if (st.auto_inc)
				next_st.addr = st.addr + 5'h01;
		end

		case (st.state)
			S_SLEEP: begin
				// R1 idle until powered
				if (power_on_bit) begin
					go       = S_PWRUP;
					go_valid = 1'b1;
				end
			end
			S_PWRUP: begin
				// R3 one step before start
				if (tmr.done) begin
					go       = S_START;
					go_valid = 1'b1;
				end
			end
			S_START: begin
				// R4 next enabled function
				go       = power_on_bit ? after_start : S_SLEEP;
				go_valid = 1'b1;
			end
			S_PACC: begin
				// R6 accumulate then convert
				if (tmr.done) begin
					go       = S_PCONV;
					go_valid = 1'b1;
				end
			end
			S_PCONV: begin
				if (tmr.done) begin
					// R13 latch proximity result
					next_st.prox_result = prox_sel;
					next_st.prox_valid  = 1'b1;
					next_st.prox_hits   = prox_pers[3:0];
					if (prox_pers[4])
						next_st.prox_int = 1'b1;
					// R5 sleep only after conversion
					go       = power_on_bit ? after_prox : S_SLEEP;
					go_valid = 1'b1;
				end
			end
			S_WAIT: begin
				if (!power_on_bit) begin
					go       = S_SLEEP;
					go_valid = 1'b1;
				end else if (tmr.done) begin
					// R8 wait end to color
					go       = after_wait;
					go_valid = 1'b1;
				end
			end
			S_COLOR: begin
				if (tmr.done) begin
					// R10 all channels latched together
					next_st.color_result = {color_adc_blue, color_adc_green,
						color_adc_red, color_adc_clear};
					next_st.color_valid  = 1'b1;
					next_st.color_hits   = color_pers[3:0];
					if (color_pers[4])
						next_st.color_int = 1'b1;
					// R11 advance without host
					go       = S_START;
					go_valid = 1'b1;
				end
			end
			default: begin
				go       = S_SLEEP;
				go_valid = 1'b1;
			end
		endcase

		if (go_valid) begin
			next_st.state = go;
			// R27 timer loaded on entry to all states but sleep and start; a wait cut short by power-off counts on in sleep
			tmr.load = go != S_SLEEP && go != S_START;
			// R9 two's-complement step counts
			case (go)
				S_PACC: begin
					tmr.unit_cycles = UNIT_W'(PULSE_CYCLES);
					tmr.units       = COUNT_W'(st.led_pulse_count);
				end
				S_PCONV: tmr.units = steps(st.prox_integ_time);
				// R7 long wait twelvefold
				S_WAIT: tmr.units = long_wait ? COUNT_W'(
					steps(st.wait_time_count) * COUNT_W'(LONG_WAIT_MULT)) :
					steps(st.wait_time_count);
				S_COLOR: tmr.units = steps(st.color_integ_time);
				default: tmr.units = COUNT_W'(1);
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st                  <= '0;
			st.state            <= S_SLEEP;
			st.color_integ_time <= TIME_RESET;
			st.prox_integ_time  <= TIME_RESET;
			st.wait_time_count  <= TIME_RESET;
			st.func_enable      <= BYTE_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign rd_data            = st.rd_data;
	assign rd_valid           = st.rd_valid;
	assign color_integrating  = st.state == S_COLOR;
	assign prox_integrating   = st.state == S_PACC || st.state == S_PCONV;
	assign color_gain_setting = st.gain_control[GAIN_LSB +: 2];
	assign prox_diode_select  = st.gain_control[DIODE_LSB +: 2];
	// R15 sink current selection
	assign led_drive_strength = st.gain_control[DRIVE_LSB +: 2];
	// R14 one LED pulse per period
	assign led_pin_o  = 1'b0;
	assign led_pin_oe = st.state == S_PACC
		&& tmr.cyc < UNIT_W'(LED_ON_CYCLES);
	// R25 open-drain, pulled low
	assign irq_pin_o  = 1'b0;
	assign irq_pin_oe = (st.prox_int && st.func_enable[BIT_PROX_IRQ_EN])
		|| (st.color_int && st.func_enable[BIT_COLOR_IRQ_EN]);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_wake;
		st.state == S_SLEEP && power_on_bit;
	endsequence
	sequence s_color_end;
		st.state == S_COLOR && tmr.done;
	endsequence

	AST_SLEEP_HOLD: assert property ( // R1
		st.state == S_SLEEP && !power_on_bit |=> st.state == S_SLEEP)
		else $error("left sleep without power-on");
	AST_WAKE_DELAY: assert property ( // R3
		s_wake |=> st.state == S_PWRUP && u_timer.st.left == COUNT_W'(1))
		else $error("power-up delay not started");
	AST_START_ORDER: assert property ( // R4
		st.state == S_START && power_on_bit && prox_enable_bit && st.led_pulse_count != 8'h00
		|=> st.state == S_PACC)
		else $error("proximity not first after start");
	AST_FINISH_OFF: assert property ( // R5
		st.state == S_COLOR && !power_on_bit && !tmr.done |=> st.state == S_COLOR)
		else $error("conversion abandoned at power-off");
	AST_PROX_NEXT: assert property ( // R6
		st.state == S_PCONV && tmr.done && power_on_bit && wen |=> st.state == S_WAIT)
		else $error("no advance after proximity conversion");
	AST_WAIT_COLOR: assert property ( // R8
		st.state == S_WAIT && tmr.done && power_on_bit && color_enable_bit |=> st.state == S_COLOR)
		else $error("wait end did not enter color");
	AST_COLOR_LATCH: assert property ( // R10
		s_color_end |=> st.color_result[0] == $past(color_adc_clear)
		&& st.state == S_START)
		else $error("color result not latched");
	AST_INT_HOLD: assert property ( // R22
		st.prox_int && !prox_clr_cmd |=> st.prox_int)
		else $error("proximity interrupt dropped without clear");
	AST_CLEAR: assert property ( // R24
		color_clr_cmd && !(st.state == S_COLOR && tmr.done)
		|=> !st.color_int)
		else $error("color interrupt not cleared");
	AST_PIN_LOW: assert property ( // R25
		st.color_int && color_enable_bit && st.func_enable[BIT_COLOR_IRQ_EN]
		|-> irq_pin_oe && !irq_pin_o)
		else $error("pending interrupt not on pin");
	AST_LED_WINDOW: assert property ( // R14
		led_pin_oe |-> st.state == S_PACC && tmr.cyc < UNIT_W'(PULSE_CYCLES))
		else $error("LED driven outside accumulate");
endmodule

// *** tb/host_model.sv ***
// Host side model driving the register port of the sequencer
`timescale 1ns/1ns
module host_model (
	input  wire logic clk,
	output logic       cmd_valid,
	output logic [7:0] cmd_byte,
	output logic       wr_valid,
	output logic [7:0] wr_data,
	output logic       rd_req
);
	initial begin
		cmd_valid = 1'b0;
		cmd_byte = 8'h00;
		wr_valid = 1'b0;
		wr_data = 8'h00;
		rd_req = 1'b0;
	end
	// Kind 0 command, 1 write, 2 read; one strobe cycle each
	task automatic strobe(input int kind, input logic [7:0] b);
		@(negedge clk);
		if (kind == 0) cmd_byte = b;
		if (kind == 1) wr_data = b;
		cmd_valid = (kind == 0);
		wr_valid = (kind == 1);
		rd_req = (kind == 2);
		@(negedge clk);
		cmd_valid = 1'b0;
		wr_valid = 1'b0;
		rd_req = 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		strobe(0, {3'h4, a});
		strobe(1, d);
	endtask
	task automatic rd(input logic [4:0] a);
		strobe(0, {3'h4, a});
		strobe(2, 8'h00);
	endtask
	task automatic configure();
		logic [15:0] t [9];
		t = '{16'h02FF, 16'h01FE, 16'h0501, 16'h0702, 16'h0801,
		      16'h0A02, 16'h0D02, 16'h0E02, 16'h0FE3};
		foreach (t[i]) wr(t[i][12:8], t[i][7:0]);
	endtask
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench of the measurement sequencer
`timescale 1ns/1ns
module tb_top;
	import sequencer_pkg::*;
	localparam int STEP     = 10;
	localparam int COL_LEN  = STEP * 2;
	localparam int PROX_LEN = 2 * PULSE_CYCLES + STEP;
	localparam int WAIT_LEN = STEP * LONG_WAIT_MULT;
	logic        clk, rst_n, meas_on, prox_q, col_q, oe_q;
	logic        cmd_valid, wr_valid, rd_req, rd_valid;
	logic        color_integrating, prox_integrating;
	logic        led_pin_o, led_pin_oe, irq_pin_o, irq_pin_oe;
	logic [7:0]  cmd_byte, wr_data, rd_data;
	logic [15:0] c_clr, c_red, c_grn, c_blu, p_red, p_clr;
	logic [1:0]  gain_o, diode_o, drive_o;
	logic [7:0]  exp_q [$];
	int          err_count, check_count, seed, n;
	int          plen, clen, gap, oe_n, pulses;
	host_model u_host (.clk(clk), .cmd_valid(cmd_valid),
		.cmd_byte(cmd_byte), .wr_valid(wr_valid), .wr_data(wr_data),
		.rd_req(rd_req));
	color_proximity_measure_sequencer #(.STEP_CYC(STEP))
	u_color_proximity_measure_sequencer (.clk(clk), .rst_n(rst_n),
		.cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .wr_valid(wr_valid),
		.wr_data(wr_data), .rd_req(rd_req), .rd_data(rd_data),
		.rd_valid(rd_valid), .color_adc_clear(c_clr),
		.color_adc_red(c_red), .color_adc_green(c_grn),
		.color_adc_blue(c_blu), .prox_adc_red(p_red),
		.prox_adc_clear(p_clr), .color_integrating(color_integrating),
		.prox_integrating(prox_integrating), .color_gain_setting(gain_o),
		.prox_diode_select(diode_o), .led_drive_strength(drive_o),
		.led_pin_i(led_pin_oe ? led_pin_o : 1'b1), .led_pin_o(led_pin_o),
		.led_pin_oe(led_pin_oe), .irq_pin_i(irq_pin_oe ? irq_pin_o : 1'b1),
		.irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic check(input string nm, input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic give_verdict();
		if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic rd_exp(input logic [4:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_host.rd(a);
	endtask
	// Sel 0 watches color, 1 proximity; n returns cycles waited
	task automatic wait_lvl(input int sel, input logic lvl, output int n);
		n = 0;
		while (((sel == 0) ? color_integrating : prox_integrating) !== lvl) begin
			@(negedge clk);
			n++;
			if (n > 5000) begin
				err_count++;
				give_verdict();
			end
		end
	endtask
	always @(posedge clk) begin
		if (rd_valid === 1'b1) check("rd_data", rd_data, exp_q.pop_front());
		if (meas_on === 1'b1 && prox_q === 1'b1 && prox_integrating === 1'b0) begin
			check("prox_len", plen, PROX_LEN);
			check("led_on", oe_n, 2 * LED_ON_CYCLES);
			check("pulses", pulses, 2);
		end
		if (meas_on === 1'b1 && col_q === 1'b1 && color_integrating === 1'b0)
			check("color_len", clen, COL_LEN);
		if (meas_on === 1'b1 && col_q === 1'b0 && color_integrating === 1'b1)
			check("wait_gap", gap, WAIT_LEN);
		gap = (prox_q === 1'b1) ? 1 : gap + 1;
		plen = (prox_integrating === 1'b1) ? plen + 1 : 0;
		clen = (color_integrating === 1'b1) ? clen + 1 : 0;
		oe_n = (prox_integrating !== 1'b1) ? 0 : oe_n + (led_pin_oe === 1'b1);
		pulses = (prox_integrating !== 1'b1) ? 0
			: pulses + (led_pin_oe === 1'b1 && oe_q === 1'b0);
		prox_q = prox_integrating;
		col_q = color_integrating;
		oe_q = led_pin_oe;
	end
	initial begin
		seed = 32'h3f25;
		{err_count, check_count, plen, clen, gap, oe_n, pulses} = '0;
		{rst_n, meas_on, prox_q, col_q, oe_q} = '0;
		c_clr = 16'h0050;
		c_red = 16'($random(seed));
		c_grn = 16'($random(seed));
		c_blu = 16'($random(seed));
		p_red = 16'($random(seed)) | 16'h0100;
		p_clr = 16'($random(seed));
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		rd_exp(REG_FUNC_ENABLE, BYTE_RESET);
		rd_exp(REG_COLOR_TIME, TIME_RESET);
		rd_exp(REG_DEVICE_STATUS, BYTE_RESET);
		rd_exp(5'h10, 8'h00);
		u_host.configure();
		check("idle", {color_integrating, prox_integrating}, 2'b00);
		check("pad_cfg", {drive_o, diode_o, gain_o}, 6'h3B);
		u_host.wr(REG_FUNC_ENABLE, 8'hDF);
		wait_lvl(1, 1'b1, n);
		check("pwrup", n >= STEP && n <= STEP + 4, 1'b1);
		meas_on = 1'b1;
		wait_lvl(0, 1'b1, n);
		wait_lvl(0, 1'b0, n);
		c_clr = 16'h0150;
		check("irq_pin", irq_pin_oe, 1'b1);
		rd_exp(REG_FUNC_ENABLE, 8'h1F);
		rd_exp(REG_DEVICE_STATUS, 8'h33);
		rd_exp(5'h14, 8'h50);
		rd_exp(5'h15, 8'h00);
		rd_exp(5'h16, c_red[7:0]);
		rd_exp(5'h17, c_red[15:8]);
		rd_exp(5'h1C, p_red[7:0]);
		rd_exp(5'h1D, p_red[15:8]);
		u_host.strobe(0, {1'b1, TYPE_SPECIAL, SF_PROX_CLR});
		rd_exp(REG_DEVICE_STATUS, 8'h13);
		check("irq_held", irq_pin_oe, 1'b1);
		u_host.strobe(0, {1'b1, TYPE_SPECIAL, SF_COLOR_CLR});
		rd_exp(REG_DEVICE_STATUS, 8'h03);
		check("irq_clr", irq_pin_oe, 1'b0);
		wait_lvl(0, 1'b1, n);
		wait_lvl(0, 1'b0, n);
		rd_exp(REG_DEVICE_STATUS, 8'h23);
		check("irq_gated", irq_pin_oe, 1'b0);
		u_host.strobe(0, {1'b1, TYPE_SPECIAL, SF_BOTH_CLR});
		rd_exp(REG_DEVICE_STATUS, 8'h03);
		wait_lvl(1, 1'b1, n);
		u_host.wr(REG_FUNC_ENABLE, 8'h00);
		wait_lvl(1, 1'b0, n);
		check("finish", n > PULSE_CYCLES, 1'b1);
		repeat (PROX_LEN) @(negedge clk);
		check("asleep", {color_integrating, prox_integrating}, 2'b00);
		check("reads", exp_q.size(), 0);
		give_verdict();
	end
endmodule
